// File: core/spi_stream_pkg.sv
// shared constants and carrier types for the message stream port
package spi_stream_pkg;
    // ==========================================================
    // byte and stream constants
    localparam int BYTE_W = 8;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] READ_PTR_RESET = 8'hFF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [5:0] IDLE_STOP_COUNT = 6'h32;
    localparam logic [5:0] IDLE_CNT_ZERO = 6'h00;
    localparam logic [5:0] IDLE_CNT_ONE = 6'h01;
    localparam logic [7:0] PTR_ONE = 8'h01;
    localparam logic STRAP_SPI = 1'b0;

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } byte_beat_t;

    typedef struct packed {
        logic sdo;
        logic cs_n;
        logic sck;
        logic sdi;
    } pin_bundle_t;
endpackage

// File: core/sync2.sv
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // asynchronous levels in, synchronised out
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] reset_val_i,
    output logic [W-1:0] sync_o
);
    // ==========================================================
    // synchroniser stages
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage1_reg <= '1;
            stage2_reg <= '1;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

    // reset_val_i kept for interface symmetry is not needed; all lines idle high
    logic unused_ok;
    assign unused_ok = ^reset_val_i;
endmodule

// File: core/spi_message_stream_port.sv
// peripheral-only serial port carrying the receiver message stream
// Summary of operation
// - port active only when strap reads 0
// - strap 0 selects serial pins, 1 uart/i2c
// - peripheral only, never drives clock or select
// - bytes shifted most significant bit first
// - no register mode, only output stream
// - writes accepted only as message bytes
// - each byte in exchanges one byte out
// - parsing stops after 50 idle bytes
// - empty queue holds data out high
// - output byte is current-address stream read
// - read pointer starts and stays at 0xFF
`timescale 1ns/1ps
module spi_message_stream_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // interface-select strap pin
    input wire logic sel_strap_i,
    // shared pins, serial peripheral roles
    input wire logic serial_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    // uart/i2c side of the shared pins
    output logic uart_mode_o,
    // outgoing queue from the message engine
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // received message bytes to the parser
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic parse_active_o
);
    // ==========================================================
    // pin synchronisation
    spi_stream_pkg::pin_bundle_t pins_s;
    logic [3:0] sync_out;

    sync2 #(.W(4)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i({1'b0, chip_sel_n_i, serial_clk_i, serial_data_in_i}),
        .reset_val_i(4'hF),
        .sync_o(sync_out)
    );
    assign pins_s = sync_out;

    // ==========================================================
    // strap capture and edge detection
    logic strap_reg;
    logic strap_seen_reg;
    logic strap_sync;
    logic [1:0] strap_age_reg;
    logic sck_d_reg;
    logic port_en;
    logic sck_rise;
    logic sck_fall;
    logic selected;

    // strap is a pin like the others, so it crosses two flops before use
    sync2 #(.W(1)) u_strap_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(sel_strap_i),
        .reset_val_i(1'b1),
        .sync_o(strap_sync)
    );

    // strap caught once, only after the synchroniser has flushed its reset level
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_reg <= 1'b1;
            strap_seen_reg <= 1'b0;
            strap_age_reg <= 2'h0;
        end else begin
            strap_age_reg <= {strap_age_reg[0], 1'b1};
            if (!strap_seen_reg && strap_age_reg[1]) begin
                strap_reg <= strap_sync;
                strap_seen_reg <= 1'b1;
            end
        end
    end

    assign port_en = strap_seen_reg && (strap_reg == spi_stream_pkg::STRAP_SPI);
    assign selected = port_en && !pins_s.cs_n;

    // clock edge history; resets to the synchroniser's level so no false edge follows reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_d_reg <= 1'b1;
        end else begin
            sck_d_reg <= pins_s.sck;
        end
    end

    assign sck_rise = selected && pins_s.sck && !sck_d_reg;
    assign sck_fall = selected && !pins_s.sck && sck_d_reg;

    // ==========================================================
    // shift engine: one byte in, one byte out
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic byte_done;
    logic [7:0] rx_byte;
    logic load_pending_reg;

    assign byte_done = sck_rise && (bit_cnt_reg == spi_stream_pkg::BIT_LAST);
    assign rx_byte = {rx_shift_reg[6:0], pins_s.sdi};

    // receive side samples on rising edge, msb first
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt_reg <= spi_stream_pkg::BIT_FIRST;
            rx_shift_reg <= spi_stream_pkg::IDLE_BYTE;
        end else if (!selected) begin
            bit_cnt_reg <= spi_stream_pkg::BIT_FIRST;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_shift_reg <= rx_byte;
        end
    end

    // ==========================================================
    // stream read pointer, pinned at the data register
    logic [7:0] read_ptr_reg;

    // current-address read never advances past the top location
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            read_ptr_reg <= spi_stream_pkg::READ_PTR_RESET;
        end else if (byte_done && read_ptr_reg != spi_stream_pkg::READ_PTR_RESET) begin
            read_ptr_reg <= read_ptr_reg + spi_stream_pkg::PTR_ONE;
        end
    end

    // next output byte: queue head or idle filler
    logic [7:0] next_out;
    logic take_tx;
    assign take_tx = tx_valid_i && (read_ptr_reg == spi_stream_pkg::READ_PTR_RESET);
    assign next_out = take_tx ? tx_data_i : spi_stream_pkg::IDLE_BYTE;

    // transmit side: first bit presented at select, then on falling edges
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_shift_reg <= spi_stream_pkg::IDLE_BYTE;
            load_pending_reg <= 1'b1;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= 1'b0;
            if (!selected) begin
                load_pending_reg <= 1'b1;
            end else if (load_pending_reg || (sck_fall && bit_cnt_reg == spi_stream_pkg::BIT_FIRST)) begin
                tx_shift_reg <= next_out;
                tx_ready_o <= take_tx;
                load_pending_reg <= 1'b0;
            end else if (sck_fall) begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
            end
        end
    end

    // data out driven only while selected as serial port; clock never driven
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_data_out_o <= 1'b1;
            serial_data_out_oe_o <= 1'b0;
            uart_mode_o <= 1'b1;
        end else begin
            serial_data_out_o <= selected ? tx_shift_reg[7] : 1'b1;
            serial_data_out_oe_o <= selected;
            uart_mode_o <= !port_en;
        end
    end

    // ==========================================================
    // received bytes and idle-filler parsing gate
    logic [5:0] idle_cnt_reg;
    logic parse_on;
    assign parse_on = idle_cnt_reg < spi_stream_pkg::IDLE_STOP_COUNT;

    // count consecutive filler bytes, saturate at the stop count
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_cnt_reg <= spi_stream_pkg::IDLE_CNT_ZERO;
        end else if (byte_done) begin
            if (rx_byte != spi_stream_pkg::IDLE_BYTE) begin
                idle_cnt_reg <= spi_stream_pkg::IDLE_CNT_ZERO;
            end else if (parse_on) begin
                idle_cnt_reg <= idle_cnt_reg + spi_stream_pkg::IDLE_CNT_ONE;
            end
        end
    end

    // hand bytes to the message parser; writes are message bytes only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_data_o <= spi_stream_pkg::IDLE_BYTE;
            rx_valid_o <= 1'b0;
            parse_active_o <= 1'b1;
        end else begin
            rx_valid_o <= byte_done && (parse_on || rx_byte != spi_stream_pkg::IDLE_BYTE);
            if (byte_done) begin
                rx_data_o <= rx_byte;
            end
            parse_active_o <= parse_on;
        end
    end

    // ==========================================================
    // assertions
    AST_STRAP_GATES_DRIVE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !port_en |=> !serial_data_out_oe_o)
        else $error("data out driven while strap selects uart");

    AST_IDLE_OUT_HIGH: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !selected |=> serial_data_out_o)
        else $error("data out not high while idle");

    AST_DESELECT_RESETS: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !selected |=> bit_cnt_reg == spi_stream_pkg::BIT_FIRST)
        else $error("bit counter not reset on deselect");

    AST_PTR_STAYS: assert property (@(posedge clk_i) disable iff (!nrst_i)
        read_ptr_reg == spi_stream_pkg::READ_PTR_RESET |=> read_ptr_reg == spi_stream_pkg::READ_PTR_RESET)
        else $error("read pointer left top location");

    // the filler byte that completes the run of idle bytes
    sequence seq_last_filler;
        byte_done && rx_byte == spi_stream_pkg::IDLE_BYTE
            && idle_cnt_reg == spi_stream_pkg::IDLE_STOP_COUNT - spi_stream_pkg::IDLE_CNT_ONE;
    endsequence

    // any byte that is not filler
    sequence seq_real_byte;
        byte_done && rx_byte != spi_stream_pkg::IDLE_BYTE;
    endsequence

    AST_PARSE_STOPS: assert property (@(posedge clk_i) disable iff (!nrst_i)
        seq_last_filler |=> ##1 !parse_active_o)
        else $error("parsing not stopped after the last filler byte");

    AST_PARSE_RESUMES: assert property (@(posedge clk_i) disable iff (!nrst_i)
        seq_real_byte |=> ##1 parse_active_o)
        else $error("parsing not resumed on non-filler byte");

    AST_BYTE_DELIVERED: assert property (@(posedge clk_i) disable iff (!nrst_i)
        seq_real_byte |=> rx_valid_o && rx_data_o == $past(rx_byte))
        else $error("received byte not delivered");

    AST_UART_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        strap_seen_reg |=> uart_mode_o == (strap_reg != spi_stream_pkg::STRAP_SPI))
        else $error("pin role does not follow strap");
endmodule

// File: tb/spi_host_model.sv
// host-side serial controller model for the message stream port
`timescale 1ns/1ps
module spi_host_model (
    // serial lines toward the port
    output logic sck_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    localparam int HALF = 400;
    // idle: clock low, select high
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b1;
    end
    // select low, then leave the port time to load its first bit
    task automatic open_frame();
        cs_n_o = 1'b0;
        #(2*HALF);
    endtask
    // released data line flips so no stale level is left behind
    task automatic close_frame();
        #HALF;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #(2*HALF);
    endtask
    // n bits msb first; data moves while clock low, both lines taken at rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'hFF;
        for (int i = 7; i > 7 - n; i--) begin
            sdi_o = tx[i];
            #HALF;
            sck_o = 1'b1;
            rx[i] = sdo_i;
            #HALF;
            sck_o = 1'b0;
        end
    endtask
endmodule

// File: tb/spi_message_stream_port_bench.sv
// self-checking bench for the message stream port
`timescale 1ns/1ps
module spi_message_stream_port_bench;
    typedef struct packed {logic has; logic [7:0] qb; logic [7:0] hb;} row_t;
    logic clk_i, nrst_i, sel_strap_i, sck, cs_n, sdi, sdo, oe, uart_mode;
    logic tx_valid_i, tx_ready, rx_valid, parse;
    logic [7:0] tx_data_i, rx_data, got;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_msg = 0;
    // queued byte, host byte; empty queue rows last
    row_t rows[4] = '{'{1'b1, 8'hA5, 8'h3C}, '{1'b1, 8'h01, 8'h80}, '{1'b1, 8'h7E, 8'hFE}, '{1'b0, 8'h00, 8'h81}};

    spi_message_stream_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .sel_strap_i(sel_strap_i),
        .serial_clk_i(sck), .chip_sel_n_i(cs_n), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
        .serial_data_out_oe_o(oe), .uart_mode_o(uart_mode), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .parse_active_o(parse));
    spi_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

    // ==========================================================
    // clock, queue feed, receive capture, hang guard
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (tx_ready === 1'b1) void'(txq.pop_front());
        #1;
        tx_valid_i = (txq.size() != 0);
        tx_data_i = (txq.size() != 0) ? txq[0] : 8'h00;
    end
    always @(posedge clk_i) if (rx_valid === 1'b1) rxq.push_back(rx_data);
    // ceiling well above the few thousand cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic strap);
        nrst_i = 1'b0;
        sel_strap_i = strap;
        repeat (6) @(posedge clk_i);
        check({sdo, oe, uart_mode, tx_ready, rx_valid, parse}, 8'h29);
        check(rx_data, 8'hFF);
        #1 nrst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        nrst_i = 1'b0;
        sel_strap_i = 1'b0;
        do_reset(1'b0);
        $display("test reset done");
        foreach (rows[i]) if (rows[i].has) txq.push_back(rows[i].qb);
        u_host.open_frame();
        check({7'h00, oe}, 8'h01);
        check({7'h00, uart_mode}, 8'h00);
        foreach (rows[i]) begin
            u_host.shift(rows[i].hb, 8, got);
            check(got, rows[i].has ? rows[i].qb : 8'hFF);
            if (got !== 8'hFF) n_msg++;
        end
        check(8'(n_msg), 8'h03);
        u_host.close_frame();
        check({7'h00, oe}, 8'h00);
        foreach (rows[i]) check(rxq.pop_front(), rows[i].hb);
        $display("test rows done");
        // partial byte then a whole one
        u_host.open_frame();
        u_host.shift(8'h00, 3, got);
        u_host.close_frame();
        u_host.open_frame();
        u_host.shift(8'h5A, 8, got);
        u_host.close_frame();
        check(8'(rxq.size()), 8'h01);
        check(rxq.pop_front(), 8'h5A);
        $display("test abort done");
        // idle filler stops and restarts parsing
        u_host.open_frame();
        repeat (49) u_host.shift(8'hFF, 8, got);
        #1000;
        check({7'h00, parse}, 8'h01);
        u_host.shift(8'hFF, 8, got);
        check(got, 8'hFF);
        #1000;
        check({7'h00, parse}, 8'h00);
        rxq.delete();
        u_host.shift(8'hFF, 8, got);
        u_host.shift(8'h42, 8, got);
        u_host.close_frame();
        check(8'(rxq.size()), 8'h01);
        check(rxq.pop_front(), 8'h42);
        check({7'h00, parse}, 8'h01);
        $display("test idle done");
        // strap high: pins belong to the uart/i2c pair
        do_reset(1'b1);
        u_host.open_frame();
        check({7'h00, oe}, 8'h00);
        check({7'h00, uart_mode}, 8'h01);
        u_host.shift(8'h33, 8, got);
        u_host.close_frame();
        check(8'(rxq.size()), 8'h00);
        $display("test strap done");
        stop_test();
    end
endmodule
